// ---- src/tig_pkg.sv ----
package tig_pkg;
  // Filter settings
  localparam logic [1:0] TIG_FILT_OFF = 2'h0;
  localparam logic [1:0] TIG_FILT_MED = 2'h1;
  localparam logic [1:0] TIG_FILT_HIGH = 2'h2;
  // Filter settle times in ns and derived cycle counts at 25 MHz
  localparam int TIG_CLK_NS = 40;
  localparam int TIG_FILT_MED_NS = 400;
  localparam int TIG_FILT_HIGH_NS = 2000;
  localparam int TIG_FILT_MED_CYC = (TIG_FILT_MED_NS + TIG_CLK_NS - 1) / TIG_CLK_NS;
  localparam int TIG_FILT_HIGH_CYC = (TIG_FILT_HIGH_NS + TIG_CLK_NS - 1) / TIG_CLK_NS;
  localparam int TIG_FILT_CW = 8;
  // Exposure trigger modes
  localparam logic [1:0] TIG_TRG_OFF = 2'h0;
  localparam logic [1:0] TIG_TRG_START = 2'h1;
  localparam logic [1:0] TIG_TRG_CTRL = 2'h2;
  // Acquire-enable input functions
  localparam logic [1:0] TIG_ACQ_AUTO = 2'h0;
  localparam logic [1:0] TIG_ACQ_EXT = 2'h1;
  localparam logic [1:0] TIG_ACQ_SEQSTOP = 2'h2;
  localparam int TIG_CNT_W = 16;
  typedef enum logic [1:0] {
    TIG_REC_IDLE = 2'b00,
    TIG_REC_RUN = 2'b01,
    TIG_REC_DRAIN = 2'b11
  } tig_rec_e;
endpackage : tig_pkg

// ---- src/tig_cond.sv ----
`timescale 1ns/100ps
// Synchronise, filter and polarise one external input
module tig_cond
  import tig_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  input wire logic [1:0] i_filt,
  input wire logic i_invert,
  output logic o_level,
  output logic o_rise
);
  logic s1_r, s2_r;
  logic filt_r, filt_nxt;
  logic lvl_r, lvl_nxt;
  logic [TIG_FILT_CW-1:0] cnt_r, cnt_nxt;
  logic [TIG_FILT_CW-1:0] lim;

  // Refuse a settle count that the filter counter cannot reach
  if (TIG_FILT_HIGH_CYC >= (1 << TIG_FILT_CW)) begin : g_filt_chk
    $error("filter count too wide");
  end

  // Two-flop synchroniser
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
    end
  end

  // Filter needs a stable input for lim+1 cycles; polarity applied after
  always_comb begin
    unique case (i_filt)
      TIG_FILT_MED: lim = TIG_FILT_CW'(TIG_FILT_MED_CYC);
      TIG_FILT_HIGH: lim = TIG_FILT_CW'(TIG_FILT_HIGH_CYC);
      default: lim = '0;
    endcase
    filt_nxt = filt_r;
    cnt_nxt = '0;
    if (s2_r != filt_r) begin
      if (cnt_r >= lim) filt_nxt = s2_r;
      else cnt_nxt = cnt_r + 1'b1;
    end
    lvl_nxt = filt_nxt ^ i_invert;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      filt_r <= 1'b0;
      cnt_r <= '0;
      lvl_r <= 1'b0;
    end else begin
      filt_r <= filt_nxt;
      cnt_r <= cnt_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign o_level = lvl_r;
  assign o_rise = lvl_nxt & ~lvl_r;

  property p_filt_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_filt == TIG_FILT_HIGH && $stable(i_filt) && s2_r != filt_r && cnt_r == '0)
      |=> $stable(filt_r);
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter passed change early");
endmodule : tig_cond

// ---- src/tig_gate.sv ----
`timescale 1ns/100ps
// Summary of operation
// - External acquire, high polarity: store while high
// - External acquire, low polarity: store while low
// - Sequence stop: keep recording while input active
// - Stop event: halt now or after post-count
// - Polarity selects active-high or active-low sense
// - Selectable filter off/medium/high adds delay
// - Ignore exposure trigger edge while readout busy; exposure level still follows
// - Trigger input for exposure, enable for acquire
// - Sample acquire-enable at exposure start
// - Exposure-start edge gated by acquire enable
module tig_gate
  import tig_pkg::*;
#(
  parameter int CNT_W = TIG_CNT_W
)(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_acq_pin,
  input wire logic i_trg_pin,
  input wire logic [1:0] i_acq_filt,
  input wire logic [1:0] i_trg_filt,
  input wire logic i_acq_invert,
  input wire logic i_trg_invert,
  input wire logic [1:0] i_acq_func,
  input wire logic [1:0] i_trg_mode,
  input wire logic i_record_start,
  input wire logic i_soft_event,
  input wire logic [CNT_W-1:0] i_post_event_frame_count,
  input wire logic i_exp_start,
  input wire logic i_frame_stored,
  input wire logic i_busy,
  output logic o_exp_trigger,
  output logic o_exp_level,
  output logic o_frame_keep,
  output logic o_recording,
  output logic o_sequence_stop_event
);
  logic acq_lvl, acq_rise_unused, trg_lvl, trg_rise;
  logic keep_r, keep_nxt;
  logic stop_r, stop_nxt;
  logic acq_prev_r;
  tig_rec_e st_r, st_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic ext_evt;

  // Refuse counter widths the recorder logic cannot serve
  if (CNT_W < 1 || CNT_W > 32) begin : g_cnt_chk
    $error("CNT_W out of range");
  end

  // Acquire-enable and exposure-trigger conditioners
  tig_cond u_acq (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_pin(i_acq_pin), .i_filt(i_acq_filt),
    .i_invert(i_acq_invert), .o_level(acq_lvl), .o_rise(acq_rise_unused)
  );
  tig_cond u_trg (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_pin(i_trg_pin), .i_filt(i_trg_filt),
    .i_invert(i_trg_invert), .o_level(trg_lvl), .o_rise(trg_rise)
  );

  // Exposure trigger: active edge, gated and busy-masked
  always_comb begin
    o_exp_trigger = 1'b0;
    if (!i_busy && trg_rise) begin
      unique case (i_trg_mode)
        TIG_TRG_START: o_exp_trigger = (i_acq_func != TIG_ACQ_EXT) || acq_lvl;
        TIG_TRG_CTRL: o_exp_trigger = 1'b1;
        default: o_exp_trigger = 1'b0;
      endcase
    end
  end
  assign o_exp_level = (i_trg_mode == TIG_TRG_CTRL) & trg_lvl;

  // Stop event: inactive level reached, or software command
  assign ext_evt = (i_acq_func == TIG_ACQ_SEQSTOP) && acq_prev_r && !acq_lvl;

  // Frame keep sampled at exposure start; recorder state
  always_comb begin
    keep_nxt = keep_r;
    if (i_exp_start) begin
      keep_nxt = (i_acq_func == TIG_ACQ_EXT) ? acq_lvl : 1'b1;
    end
    stop_nxt = 1'b0;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      TIG_REC_IDLE: begin
        if (i_record_start) st_nxt = TIG_REC_RUN;
      end
      TIG_REC_RUN: begin
        if (ext_evt || (i_acq_func == TIG_ACQ_SEQSTOP && i_soft_event)) begin
          stop_nxt = 1'b1;
          cnt_nxt = i_post_event_frame_count;
          st_nxt = (i_post_event_frame_count == '0) ? TIG_REC_IDLE : TIG_REC_DRAIN;
        end
      end
      TIG_REC_DRAIN: begin
        if (i_frame_stored) begin
          cnt_nxt = cnt_r - 1'b1;
          if (cnt_r == CNT_W'(1)) st_nxt = TIG_REC_IDLE;
        end
      end
      default: st_nxt = TIG_REC_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      keep_r <= 1'b1;
      stop_r <= 1'b0;
      st_r <= TIG_REC_IDLE;
      cnt_r <= '0;
      acq_prev_r <= 1'b0; // Matches level reset, no false stop edge
    end else begin
      keep_r <= keep_nxt;
      stop_r <= stop_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      acq_prev_r <= acq_lvl;
    end
  end

  assign o_frame_keep = keep_r;
  assign o_recording = (st_r != TIG_REC_IDLE);
  assign o_sequence_stop_event = stop_r;

  property p_busy_block;
    @(posedge i_clk) disable iff (!i_rst_n) i_busy |-> !o_exp_trigger;
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("trigger passed while busy");

  property p_gate;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_trg_mode == TIG_TRG_START && i_acq_func == TIG_ACQ_EXT && !acq_lvl) |-> !o_exp_trigger;
  endproperty
  a_gate: assert property (p_gate) else $error("ungated exposure start");

  property p_keep;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_exp_start && i_acq_func == TIG_ACQ_EXT) |=> (o_frame_keep == $past(acq_lvl));
  endproperty
  a_keep: assert property (p_keep) else $error("frame keep not sampled");

  property p_hold_keep;
    @(posedge i_clk) disable iff (!i_rst_n) !i_exp_start |=> $stable(o_frame_keep);
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("keep changed off exposure");

  property p_stop_now;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_r == TIG_REC_RUN && ext_evt && i_post_event_frame_count == '0) |=> !o_recording;
  endproperty
  a_stop_now: assert property (p_stop_now) else $error("no immediate halt");

  property p_keep_rec;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_r == TIG_REC_RUN && i_acq_func == TIG_ACQ_SEQSTOP && acq_lvl && !i_soft_event)
      |=> o_recording;
  endproperty
  a_keep_rec: assert property (p_keep_rec) else $error("recording dropped while high");

  property p_drain;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_r == TIG_REC_DRAIN && cnt_r == CNT_W'(1) && i_frame_stored) |=> !o_recording;
  endproperty
  a_drain: assert property (p_drain) else $error("drain overran");

  property p_drain_stay;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_r == TIG_REC_DRAIN && cnt_r > CNT_W'(1)) |=> o_recording;
  endproperty
  a_drain_stay: assert property (p_drain_stay) else $error("drain ended early");

  // Stop event with a post count enters the drain
  property p_stop_drain;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_r == TIG_REC_RUN && ext_evt && i_post_event_frame_count != '0)
      |=> (o_recording && o_sequence_stop_event);
  endproperty
  a_stop_drain: assert property (p_stop_drain) else $error("no drain after stop");

  // Stop event stands one cycle only
  property p_stop_pulse;
    @(posedge i_clk) disable iff (!i_rst_n)
      o_sequence_stop_event |=> !o_sequence_stop_event;
  endproperty
  a_stop_pulse: assert property (p_stop_pulse) else $error("stop event held");

  // Software stop with zero post count halts at once
  property p_soft_stop;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_r == TIG_REC_RUN && i_acq_func == TIG_ACQ_SEQSTOP && i_soft_event
        && i_post_event_frame_count == '0) |=> !o_recording;
  endproperty
  a_soft_stop: assert property (p_soft_stop) else $error("soft stop ignored");

  // Record start leaves idle
  property p_start_run;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_r == TIG_REC_IDLE && i_record_start) |=> o_recording;
  endproperty
  a_start_run: assert property (p_start_run) else $error("record start ignored");

  // Trigger mode off passes no exposure trigger
  property p_trig_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_trg_mode == TIG_TRG_OFF) |-> !o_exp_trigger;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger with mode off");

  // Exposure level only in control mode
  property p_exp_level;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_trg_mode != TIG_TRG_CTRL) |-> !o_exp_level;
  endproperty
  a_exp_level: assert property (p_exp_level) else $error("level outside control");

  // Control mode passes every idle-time edge
  property p_ctrl_pass;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_trg_mode == TIG_TRG_CTRL && !i_busy && trg_rise) |-> o_exp_trigger;
  endproperty
  a_ctrl_pass: assert property (p_ctrl_pass) else $error("control edge dropped");

  // Without external acquire every frame is kept
  property p_keep_auto;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_exp_start && i_acq_func != TIG_ACQ_EXT) |=> o_frame_keep;
  endproperty
  a_keep_auto: assert property (p_keep_auto) else $error("frame dropped in auto");
endmodule : tig_gate

// ---- bench/tig_src.sv ----
`timescale 1ns/100ps
// Contact and trigger source beyond the pins
module tig_src (
  output logic o_acq_pin,
  output logic o_trg_pin
);
  // Open contact idles high on its pull-up
  initial begin
    o_acq_pin = 1'h1;
    o_trg_pin = 1'h0;
  end
  // Contact open reads high, closed reads low
  task automatic set_contact(input logic open_c);
    o_acq_pin = open_c;
  endtask : set_contact
  // Trigger line level from the source
  task automatic drive_trg(input logic lvl);
    o_trg_pin = lvl;
  endtask : drive_trg
endmodule : tig_src

// ---- bench/tig_gate_tb_top.sv ----
`timescale 1ns/100ps
// Bench for the trigger input gating block
module tig_gate_tb_top;
  import tig_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic acq_pin, trg_pin, acq_inv, trg_inv, r_start, r_soft, r_exp, r_stored, busy;
  logic [1:0] acq_filt, trg_filt, acq_func, trg_mode;
  logic [TIG_CNT_W-1:0] count;
  logic exp_trg, exp_lvl, keep, rec, stop_ev;
  int failures = 0;
  int n_checks = 0;
  // Clock, 40 ns period
  always #20 clk = ~clk;
  tig_src tig_src_inst (.o_acq_pin(acq_pin), .o_trg_pin(trg_pin));
  tig_gate tig_gate_inst (.i_clk(clk), .i_rst_n(rst_n), .i_acq_pin(acq_pin),
    .i_trg_pin(trg_pin), .i_acq_filt(acq_filt), .i_trg_filt(trg_filt),
    .i_acq_invert(acq_inv), .i_trg_invert(trg_inv), .i_acq_func(acq_func),
    .i_trg_mode(trg_mode), .i_record_start(r_start), .i_soft_event(r_soft),
    .i_post_event_frame_count(count), .i_exp_start(r_exp), .i_frame_stored(r_stored),
    .i_busy(busy), .o_exp_trigger(exp_trg), .o_exp_level(exp_lvl), .o_frame_keep(keep),
    .o_recording(rec), .o_sequence_stop_event(stop_ev));
  // Verdict and end of run
  task automatic end_of_test;
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // One-cycle strobe: 0 start, 1 soft, 2 exposure, 3 stored
  task automatic pulse(input int w);
    r_start = (w == 0);
    r_soft = (w == 1);
    r_exp = (w == 2);
    r_stored = (w == 3);
    tick(1);
    r_start = 1'h0;
    r_soft = 1'h0;
    r_exp = 1'h0;
    r_stored = 1'h0;
  endtask : pulse
  // Trigger edge, accepted no earlier than min_at cycles
  task automatic trig(input logic lvl, input logic exp, input int min_at);
    int at;
    at = -1;
    tig_src_inst.drive_trg(lvl);
    for (int k = 0; k < 40; k++) begin
      tick(1);
      if (exp_trg === 1'h1 && at < 0) at = k;
    end
    chk("trigger", exp, at >= min_at);
    tig_src_inst.drive_trg(~lvl);
    tick(20);
  endtask : trig
  // Sense change hidden behind busy
  task automatic set_sense(input logic inv);
    busy = 1'h1;
    trg_inv = inv;
    tig_src_inst.drive_trg(inv);
    tick(10);
    busy = 1'h0;
  endtask : set_sense
  task automatic wait_stop;
    int k;
    k = 0;
    while (stop_ev !== 1'h1) begin
      if (k == 30) begin
        failures++;
        end_of_test;
      end
      k++;
      tick(1);
    end
  endtask : wait_stop
  // Main sequence
  initial begin
    acq_filt = TIG_FILT_OFF;
    trg_filt = TIG_FILT_OFF;
    acq_func = TIG_ACQ_AUTO;
    trg_mode = TIG_TRG_OFF;
    acq_inv = 1'h0;
    trg_inv = 1'h0;
    r_start = 1'h0;
    r_soft = 1'h0;
    r_exp = 1'h0;
    r_stored = 1'h0;
    busy = 1'h0;
    count = '0;
    tick(2);
    chk("keep_in_reset", 1'h1, keep);
    rst_n = 1'h1;
    trg_mode = TIG_TRG_START;
    tick(10);
    trig(1'h1, 1'h1, 0);
    busy = 1'h1;
    trig(1'h1, 1'h0, 0);
    busy = 1'h0;
    trg_filt = TIG_FILT_MED;
    trig(1'h1, 1'h1, TIG_FILT_MED_CYC);
    trg_filt = TIG_FILT_OFF;
    set_sense(1'h1);
    trig(1'h0, 1'h1, 0);
    set_sense(1'h0);
    trg_mode = TIG_TRG_CTRL;
    tig_src_inst.drive_trg(1'h1);
    tick(8);
    chk("exp_level", 1'h1, exp_lvl);
    tig_src_inst.drive_trg(1'h0);
    tick(8);
    chk("exp_level", 1'h0, exp_lvl);
    trig(1'h1, 1'h1, 0);
    trg_mode = TIG_TRG_OFF;
    trig(1'h1, 1'h0, 0);
    trg_mode = TIG_TRG_START;
    acq_func = TIG_ACQ_EXT;
    tig_src_inst.set_contact(1'h0);
    tick(8);
    trig(1'h1, 1'h0, 0);
    tig_src_inst.set_contact(1'h1);
    tick(8);
    trig(1'h1, 1'h1, 0);
    pulse(2);
    tick(2);
    chk("keep", 1'h1, keep);
    tig_src_inst.set_contact(1'h0);
    tick(8);
    chk("keep", 1'h1, keep);
    pulse(2);
    tick(2);
    chk("keep", 1'h0, keep);
    acq_inv = 1'h1;
    tick(2);
    pulse(2);
    tick(2);
    chk("keep", 1'h1, keep);
    acq_inv = 1'h0;
    acq_filt = TIG_FILT_HIGH;
    tig_src_inst.set_contact(1'h1);
    tick(20);
    pulse(2);
    tick(2);
    chk("keep", 1'h0, keep);
    tick(50);
    pulse(2);
    tick(2);
    chk("keep", 1'h1, keep);
    acq_filt = TIG_FILT_OFF;
    tig_src_inst.set_contact(1'h1);
    acq_func = TIG_ACQ_SEQSTOP;
    tick(8);
    pulse(0);
    tick(10);
    chk("recording", 1'h1, rec);
    tig_src_inst.set_contact(1'h0);
    wait_stop;
    tick(1);
    chk("recording", 1'h0, rec);
    chk("stop_event", 1'h0, stop_ev);
    count = 16'h0002;
    tig_src_inst.set_contact(1'h1);
    tick(8);
    pulse(0);
    tick(4);
    tig_src_inst.set_contact(1'h0);
    wait_stop;
    tick(2);
    chk("recording", 1'h1, rec);
    pulse(3);
    tick(2);
    chk("recording", 1'h1, rec);
    pulse(3);
    tick(2);
    chk("recording", 1'h0, rec);
    count = '0;
    tig_src_inst.set_contact(1'h1);
    tick(8);
    pulse(0);
    tick(4);
    pulse(1);
    tick(3);
    chk("recording", 1'h0, rec);
    end_of_test;
  end
endmodule : tig_gate_tb_top
